// ---- verilog/pwdt_defs.vh ----
// Constants for the programmable watchdog timer
`ifndef PWDT_DEFS_VH
`define PWDT_DEFS_VH
`define PWDT_AW 3
`define PWDT_ADDR_CFG 3'h0
`define PWDT_ADDR_CTRL 3'h1
`define PWDT_ADDR_CNT_LO 3'h2
`define PWDT_ADDR_CNT_HI 3'h3
`define PWDT_ADDR_IRQ_STAT 3'h4
`define PWDT_ADDR_IRQ_MASK 3'h5
`define PWDT_CFG_SEL_BIT 7
`define PWDT_CTRL_RE_BIT 0
`define PWDT_CTRL_RS_BIT 1
`define PWDT_CTRL_DIS_BIT 2
`define PWDT_CTRL_FLAG_BIT 3
`define PWDT_CTRL_RUN_BIT 4
`define PWDT_IRQ_REFRESH_BIT 0
`define PWDT_IRQ_BADSEQ_BIT 1
`define PWDT_IRQ_W 2
`define PWDT_CFG_RST 8'h00
`define PWDT_DIV_SLOW 7'h7F
`define PWDT_DIV_FAST 7'h01
`define PWDT_RST_PULSE_CYC 4'hF
`endif

// ---- verilog/pwdt_prescaler.v ----
// Watchdog prescaler: divide-by-2 or divide-by-128 enable pulse
`timescale 1ns/1ns
`default_nettype none
`include "pwdt_defs.vh"
module pwdt_prescaler (
    input wire clk,
    input wire rstn,
    input wire run,
    input wire clr,
    input wire sel_slow,
    output reg tick
);
    reg [6:0] cnt_r;
    wire [6:0] top;
    assign top = sel_slow ? `PWDT_DIV_SLOW : `PWDT_DIV_FAST;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 7'h00;
            tick <= 1'b0;
        end else if (clr) begin
            cnt_r <= 7'h00;
            tick <= 1'b0;
        end else if (run) begin
            if (cnt_r >= top) begin
                cnt_r <= 7'h00;
                tick <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 7'h01;
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule // pwdt_prescaler
`default_nettype wire

// ---- verilog/pwdt_sync.v ----
// Two-stage synchroniser for a level input
`timescale 1ns/1ns
`default_nettype none
module pwdt_sync (
    input wire clk,
    input wire rstn,
    input wire d,
    output reg q
);
    reg meta_r;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pwdt_sync
`default_nettype wire

// ---- verilog/pwdt_top.v ----
// Programmable watchdog timer with register port and interrupt
//
// Contract
// - Watchdog is a 16-bit up-counter driven by a prescaled clock.
// - Prescale select 0 divides by 2, select 1 divides by 128.
// - Service loads counter high byte from the reload byte.
// - Service clears counter low byte.
// - Watchdog runs after any reset with no software action.
// - Once disabled, enabling again is ignored while in active mode.
// - Counter overflow triggers an internal reset; here it only raises wdt_reset_req for 15 cycles.
// - Watchdog-caused reset sets a readable reset-cause flag.
// - Count freezes, not clears, in idle or power-down.
// - Period is 2^(1+6*sel)*(65536-reload*256) system clocks.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pwdt_defs.vh"
module pwdt_top (
    input wire clk,
    input wire rstn,
    input wire [`PWDT_AW-1:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire idle_mode,
    input wire power_down,
    output reg wdt_reset_req,
    output reg irq
);
    reg [7:0] cfg_r;
    reg [7:0] cfg_nxt;
    reg [`PWDT_IRQ_W-1:0] mask_r;
    reg [`PWDT_IRQ_W-1:0] mask_nxt;
    reg [15:0] cnt_r;
    reg [15:0] cnt_nxt;
    reg re_r;
    reg re_nxt;
    reg dis_r;
    reg dis_nxt;
    reg flag_r;
    reg flag_nxt;
    reg [3:0] pulse_r;
    reg [3:0] pulse_nxt;
    reg req_nxt;
    reg [`PWDT_IRQ_W-1:0] stat_r;
    reg [`PWDT_IRQ_W-1:0] stat_nxt;
    reg irq_nxt;
    reg [7:0] rdata_nxt;
    wire idle_s;
    wire pd_s;
    wire frozen;
    wire run;
    wire tick;
    wire cfg_wr;
    wire ctrl_wr;
    wire mask_wr;
    wire stat_rd;
    wire service;
    wire bad_seq;
    wire ovf;
    wire [7:0] reload_byte;
    wire [7:0] ctrl_rd;

    // Register hit for one strobe
    function pwdt_hit;
        input strobe;
        input [`PWDT_AW-1:0] a;
        input [`PWDT_AW-1:0] target;
        begin
            pwdt_hit = strobe && (a == target);
        end
    endfunction

    function [7:0] pwdt_pad;
        input [`PWDT_IRQ_W-1:0] v;
        begin
            pwdt_pad = {{(8-`PWDT_IRQ_W){1'b0}}, v};
        end
    endfunction

    pwdt_sync u_sync_idle (
        .clk(clk),
        .rstn(rstn),
        .d(idle_mode),
        .q(idle_s)
    );
    pwdt_sync u_sync_pd (
        .clk(clk),
        .rstn(rstn),
        .d(power_down),
        .q(pd_s)
    );

    assign frozen = idle_s | pd_s;
    assign run = ~dis_r & ~frozen;
    assign cfg_wr = pwdt_hit(wr, addr, `PWDT_ADDR_CFG);
    assign ctrl_wr = pwdt_hit(wr, addr, `PWDT_ADDR_CTRL);
    assign mask_wr = pwdt_hit(wr, addr, `PWDT_ADDR_IRQ_MASK);
    assign stat_rd = pwdt_hit(rd, addr, `PWDT_ADDR_IRQ_STAT);
    assign service = ctrl_wr && re_r && wdata[`PWDT_CTRL_RS_BIT];
    assign bad_seq = ctrl_wr && !re_r && wdata[`PWDT_CTRL_RS_BIT];
    // Select shares the top bit, so only seven reload bits reach the counter
    assign reload_byte = {cfg_r[`PWDT_CFG_SEL_BIT-1:0], 1'b0};
    // Start bit is write-only and reads back as zero
    assign ctrl_rd = {3'h0, run, flag_r, dis_r, 1'b0, re_r};
    // Overflow fires from the all-ones state on the next tick
    assign ovf = tick && run && (cnt_r == 16'hFFFF) && !service;

    pwdt_prescaler u_pre (
        .clk(clk),
        .rstn(rstn),
        .run(run),
        .clr(service),
        .sel_slow(cfg_r[`PWDT_CFG_SEL_BIT]),
        .tick(tick)
    );

    // Configuration register
    always @* begin
        cfg_nxt = cfg_r;
        if (cfg_wr) begin
            cfg_nxt = wdata;
        end
    end

    // Interrupt mask register
    always @* begin
        mask_nxt = mask_r;
        if (mask_wr) begin
            mask_nxt = wdata[`PWDT_IRQ_W-1:0];
        end
    end

    // Refresh-enable and disable bits
    always @* begin
        re_nxt = re_r;
        dis_nxt = dis_r;
        if (ctrl_wr) begin
            re_nxt = service ? 1'b0 : wdata[`PWDT_CTRL_RE_BIT];
            dis_nxt = dis_r | wdata[`PWDT_CTRL_DIS_BIT];
        end else if (wr) begin
            // Any other write breaks the sequence
            re_nxt = 1'b0;
        end
    end

    // Watchdog counter
    always @* begin
        cnt_nxt = cnt_r;
        if (service) begin
            cnt_nxt = {reload_byte, 8'h00};
        end else if (tick && run) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    // Request only: the system must route it into its reset tree
    always @* begin
        pulse_nxt = pulse_r;
        req_nxt = 1'b0;
        if (ovf) begin
            pulse_nxt = `PWDT_RST_PULSE_CYC;
            req_nxt = 1'b1;
        end else if (pulse_r != 4'h0) begin
            pulse_nxt = pulse_r - 4'h1;
            req_nxt = (pulse_r != 4'h1);
        end
    end

    // Flag survives only the watchdog reset, which rstn does not carry
    always @* begin
        flag_nxt = flag_r;
        if (ovf) begin
            flag_nxt = 1'b1;
        end else if (ctrl_wr && wdata[`PWDT_CTRL_FLAG_BIT]) begin
            flag_nxt = 1'b0;
        end
    end

    // Interrupt status, cleared by reading it
    always @* begin
        stat_nxt = stat_r;
        if (stat_rd) begin
            stat_nxt = {`PWDT_IRQ_W{1'b0}};
        end
        // Set wins over read-clear
        if (service) begin
            stat_nxt[`PWDT_IRQ_REFRESH_BIT] = 1'b1;
        end
        if (bad_seq) begin
            stat_nxt[`PWDT_IRQ_BADSEQ_BIT] = 1'b1;
        end
        irq_nxt = |(stat_nxt & mask_r);
    end

    // Read data stand one cycle after the strobe, else zero
    always @* begin
        rdata_nxt = 8'h00;
        if (rd) begin
            case (addr)
                `PWDT_ADDR_CFG: rdata_nxt = cfg_r;
                `PWDT_ADDR_CTRL: rdata_nxt = ctrl_rd;
                `PWDT_ADDR_CNT_LO: rdata_nxt = cnt_r[7:0];
                `PWDT_ADDR_CNT_HI: rdata_nxt = cnt_r[15:8];
                `PWDT_ADDR_IRQ_STAT: rdata_nxt = pwdt_pad(stat_r);
                `PWDT_ADDR_IRQ_MASK: rdata_nxt = pwdt_pad(mask_r);
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= `PWDT_CFG_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= {`PWDT_IRQ_W{1'b0}};
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            re_r <= 1'b0;
            dis_r <= 1'b0;
        end else begin
            re_r <= re_nxt;
            dis_r <= dis_nxt;
        end
    end

    // Counter wraps to zero after overflow and keeps running
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_r <= 4'h0;
            wdt_reset_req <= 1'b0;
        end else begin
            pulse_r <= pulse_nxt;
            wdt_reset_req <= req_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= {`PWDT_IRQ_W{1'b0}};
        end else begin
            stat_r <= stat_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule // pwdt_top
`default_nettype wire

// ---- sim/pwdt_chk.sv ----
// Assertion checker for the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module pwdt_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic idle_mode,
    input wire logic power_down,
    input wire logic wdt_reset_req,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic cw;
    logic cr;
    logic dis_r;
    assign cw = wr && addr == 3'h1;
    assign cr = rd && addr == 3'h1;
    // Disable is sticky until an external reset
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) dis_r <= 1'b0;
        else if (cw && wdata[2]) dis_r <= 1'b1;
    sequence s_svc; cw && wdata[0] ##1 cw && wdata[1]; endsequence
    sequence s_pulse; wdt_reset_req [*8] ##1 wdt_reset_req [*7]; endsequence
    property p_quiet; !$past(rd) |-> rdata == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("read data not idle");
    property p_svc; s_svc |=> !$rose(wdt_reset_req) [*8]; endproperty
    a_svc: assert property (p_svc) else $error("overflow right after service");
    property p_pulse; $rose(wdt_reset_req) |-> s_pulse ##1 !wdt_reset_req; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse length");
    property p_ctrl; s_svc ##2 cr |=> rdata[1:0] == 2'b00; endproperty
    a_ctrl: assert property (p_ctrl) else $error("refresh bits stuck");
    property p_flag; cr && wdt_reset_req && $past(wdt_reset_req) |=> rdata[3]; endproperty
    a_flag: assert property (p_flag) else $error("reset cause flag clear");
    property p_dis; cr && dis_r |=> !rdata[4]; endproperty
    a_dis: assert property (p_dis) else $error("enabled again");
    property p_frz; (idle_mode || power_down) [*8] |-> !$rose(wdt_reset_req); endproperty
    a_frz: assert property (p_frz) else $error("overflow while frozen");
    property p_irq; $rose(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3); endproperty
    a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule // pwdt_chk
bind pwdt_top pwdt_chk pwdt_chk_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .idle_mode(idle_mode), .power_down(power_down),
    .wdt_reset_req(wdt_reset_req), .irq(irq));
`default_nettype wire

// ---- sim/tb_pwdt_top.sv ----
// Self-checking bench for the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module tb_pwdt_top;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, idle_mode = 0, power_down = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0, rdata, v, w;
    logic wdt_reset_req, irq;
    logic [31:0] p;
    integer fail_count = 0, samples_checked = 0, n, i;
    pwdt_top pwdt_top_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .idle_mode(idle_mode), .power_down(power_down),
        .wdt_reset_req(wdt_reset_req), .irq(irq));
    initial forever #5 clk = ~clk;
    task complete_run;
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %0h expected %0h", $time, got, exp);
        end
    endtask
    // Pipeline stages blur the count by a few cycles
    task near(input logic [31:0] got, input logic [31:0] exp);
        chk(got + 8 - exp < 16 ? exp : got, exp);
    endtask
    task wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task rreg(input logic [2:0] a);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 v = rdata;
    endtask
    task svc;
        @(posedge clk);
        wr <= 1;
        addr <= 3'h1;
        wdata <= 8'h01;
        @(posedge clk);
        wdata <= 8'h02;
        @(posedge clk);
        wr <= 0;
    endtask
    task t_reset;
        rreg(3'h1);
        chk(v, 8'h10);
        rreg(3'h7);
        chk(v, 8'h00);
    endtask
    task t_service;
        wreg(3'h0, 8'h05);
        svc;
        rreg(3'h3);
        chk(v, 8'h0A);
        rreg(3'h2);
        chk(v & 8'hF0, 8'h00);
    endtask
    task t_irq;
        wreg(3'h5, 8'h02);
        wreg(3'h1, 8'h02);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1);
        rreg(3'h4);
        chk(v, 8'h03);
        repeat (3) @(posedge clk);
        #1 chk(irq, 0);
    endtask
    task t_period;
        for (i = 0; i < 2; i++) begin
            w = i ? 8'hFF : 8'h7F;
            p = (32'h1 << (1 + 6 * i)) * (32'h10000 - {w[6:0], 1'b0} * 256);
            wreg(3'h0, w);
            svc;
            for (n = 0; !wdt_reset_req && n < 70000; n++) @(negedge clk);
            near(n, p);
            rreg(3'h1);
            chk(v & 8'h08, 8'h08);
            for (n = 2; wdt_reset_req === 1'b1; n++) @(negedge clk);
            chk(n, 16);
            wreg(3'h1, 8'h08);
        end
    endtask
    task t_freeze;
        wreg(3'h0, 8'h00);
        svc;
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            idle_mode <= !i;
            power_down <= i;
            repeat (12) @(posedge clk);
            rreg(3'h2);
            w = v;
            repeat (40) @(posedge clk);
            rreg(3'h2);
            chk(v, w);
        end
        @(posedge clk);
        idle_mode <= 0;
        power_down <= 0;
    endtask
    task t_disable;
        wreg(3'h1, 8'h04);
        wreg(3'h1, 8'h10);
        svc;
        rreg(3'h1);
        chk(v & 8'h10, 8'h00);
        @(posedge clk);
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        rreg(3'h1);
        chk(v, 8'h10);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        t_reset;
        t_service;
        t_irq;
        t_period;
        t_freeze;
        t_disable;
        complete_run;
    end
    initial begin
        #900000;
        fail_count++;
        complete_run;
    end
endmodule // tb_pwdt_top
`default_nettype wire
